// >>> rtl/cpu_power_save_modes.sv
// Purpose: Doze, idle and sleep control for the processor core.
// Assumes: Core and interrupt inputs are synchronous to clock; sleep_exec,
//          irq_return and wdt_timeout are one-cycle pulses.
// Notes:   Mode clock enables are combinational from the mode register.

`default_nettype none

module cpu_power_save_modes #(
  parameter int unsigned PINS  = 8,
  parameter int unsigned CNT_W = 8
) (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  // Register port
  input  wire logic [7:0]           addr,
  input  wire logic [7:0]           wdata,
  input  wire logic                 wr,
  input  wire logic                 rd,
  output logic      [7:0]           rdata,
  // Core and interrupt logic
  input  wire logic                 sleep_exec,
  input  wire logic                 irq_pending,
  input  wire logic                 irq_request,
  input  wire logic                 global_irq_enable,
  input  wire logic                 prefetch_clears_gie,
  input  wire logic                 multicycle_busy,
  input  wire logic                 irq_return,
  output logic                      vector_fetch,
  output logic      [15:0]          vector_address,
  // Clock gating
  output logic                      core_clock_enable,
  output logic                      periph_clock_enable,
  output logic                      periph_instr_clock_enable,
  output logic                      system_clock_enable,
  // Watchdog
  input  wire logic                 wdt_timeout,
  output logic                      wdt_clear,
  output logic                      wdt_reset_request,
  // Oscillators
  input  wire logic                 fast_osc_request,
  input  wire logic                 slow_osc_request,
  input  wire logic                 secondary_osc_request,
  output logic                      high_freq_internal_osc_enable,
  output logic                      low_freq_internal_osc_enable,
  output logic                      secondary_osc_enable,
  // Converter
  input  wire logic                 converter_on,
  input  wire logic                 converter_rc_clock,
  output logic                      converter_abort,
  output logic                      converter_power,
  // Pins
  input  wire logic [PINS-1:0]      pin_periph_active,
  output logic      [PINS-1:0]      pin_hold
);

  power_save_pkg::power_mode_e mode;
  power_save_pkg::power_mode_e next_mode;

  logic       idle_select;
  logic       doze_enable;
  logic       recover_on_interrupt;
  logic       resume_throttle_on_exit;
  logic [2:0] cpu_skip_ratio;
  logic       power_down_flag;
  logic       timeout_flag;
  logic       in_handler;
  logic       fast_osc_force_on;
  logic       slow_osc_force_on;
  logic       secondary_osc_force_on;
  logic       prev_doze_enable;
  logic [2:0] prev_ratio;

  logic       next_doze_enable;
  logic       next_resume;
  logic       next_power_down_flag;
  logic       next_timeout_flag;

  doze_link_if link ();

  doze_divider #(
    .CNT_W (CNT_W)
  ) u_divider (
    .clock (clock),
    .rst_n (rst_n),
    .link  (link)
  );

  // Register decode
  wire ctrl_sel   = (addr == power_save_pkg::CTRL_OFFSET);
  wire status_sel = (addr == power_save_pkg::STATUS_OFFSET);
  wire osc_sel    = (addr == power_save_pkg::OSC_OFFSET);
  wire ctrl_wr    = wr && ctrl_sel;
  wire osc_wr     = wr && osc_sel;

  wire [7:0] ctrl_value = {idle_select, doze_enable, recover_on_interrupt,
                           resume_throttle_on_exit, 1'b0, cpu_skip_ratio};
  wire [7:0] status_value = {3'h0, in_handler, mode, timeout_flag, power_down_flag};
  wire [7:0] osc_value = {5'h0, secondary_osc_force_on, slow_osc_force_on,
                          fast_osc_force_on};
  wire [7:0] read_value = ctrl_sel   ? ctrl_value :
                          status_sel ? status_value :
                          osc_sel    ? osc_value : 8'h00;

  // Mode events
  wire running  = (mode == power_save_pkg::MODE_RUN);
  wire sleeping = (mode == power_save_pkg::MODE_SLEEP);
  wire idling   = (mode == power_save_pkg::MODE_IDLE);
  // A pending enabled interrupt turns the sleep instruction into a no-op
  wire sleep_go       = running && sleep_exec && !irq_pending;
  wire full_sleep_go  = sleep_go && !idle_select;
  // Any enabled interrupt wakes, global enable or not
  wire irq_wake       = !running && irq_pending;
  wire wdt_wake       = !running && wdt_timeout && !irq_pending;
  wire wake           = irq_wake || wdt_wake;

  // Interrupt entry waits for the core to finish a multicycle instruction
  wire irq_skip  = running && irq_request && !in_handler && prefetch_clears_gie;
  wire irq_enter = running && irq_request && !in_handler && !prefetch_clears_gie
                   && !multicycle_busy;
  wire irq_exit  = irq_return && in_handler;

  always_comb
  begin
    next_mode = mode;
    case (mode)
      power_save_pkg::MODE_RUN:
        if (sleep_go)
          next_mode = idle_select ? power_save_pkg::MODE_IDLE
                                  : power_save_pkg::MODE_SLEEP;
      power_save_pkg::MODE_IDLE:
        if (wake)
          next_mode = power_save_pkg::MODE_RUN;
      power_save_pkg::MODE_SLEEP:
        if (wake)
          next_mode = power_save_pkg::MODE_RUN;
      default:
        next_mode = power_save_pkg::MODE_RUN;
    endcase
  end

  // Hardware updates take priority over a software write in the same cycle
  always_comb
  begin
    next_doze_enable = ctrl_wr ? wdata[power_save_pkg::DOZE_ENABLE_BIT] : doze_enable;
    next_resume      = ctrl_wr ? wdata[power_save_pkg::RESUME_BIT]
                               : resume_throttle_on_exit;
    if (irq_enter)
    begin
      next_resume = doze_enable;
      if (recover_on_interrupt)
        next_doze_enable = 1'b0;
      else
        next_doze_enable = doze_enable;
    end
    else if (irq_skip)
      next_doze_enable = 1'b0;
    else if (irq_exit)
      next_doze_enable = resume_throttle_on_exit;
  end

  always_comb
  begin
    next_power_down_flag = power_down_flag;
    next_timeout_flag    = timeout_flag;
    if (sleep_go)
    begin
      next_power_down_flag = 1'b0;
      next_timeout_flag    = 1'b1;
    end
    else if (wdt_wake)
      next_timeout_flag = 1'b0;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode                    <= power_save_pkg::MODE_RUN;
      idle_select             <= power_save_pkg::CTRL_RESET[power_save_pkg::IDLE_SELECT_BIT];
      recover_on_interrupt    <= power_save_pkg::CTRL_RESET[power_save_pkg::RECOVER_BIT];
      cpu_skip_ratio          <= power_save_pkg::CTRL_RESET[2:0];
      doze_enable             <= power_save_pkg::CTRL_RESET[power_save_pkg::DOZE_ENABLE_BIT];
      resume_throttle_on_exit <= power_save_pkg::CTRL_RESET[power_save_pkg::RESUME_BIT];
    end
    else
    begin
      mode                    <= next_mode;
      doze_enable             <= next_doze_enable;
      resume_throttle_on_exit <= next_resume;
      if (ctrl_wr)
      begin
        // Idle wake never touches idle_select
        idle_select          <= wdata[power_save_pkg::IDLE_SELECT_BIT];
        recover_on_interrupt <= wdata[power_save_pkg::RECOVER_BIT];
        cpu_skip_ratio       <= wdata[power_save_pkg::RATIO_LSB +: power_save_pkg::RATIO_W];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      power_down_flag <= power_save_pkg::PD_FLAG_RESET;
      timeout_flag    <= power_save_pkg::TO_FLAG_RESET;
      in_handler      <= 1'b0;
    end
    else
    begin
      power_down_flag <= next_power_down_flag;
      timeout_flag    <= next_timeout_flag;
      // A return with no handler in progress changes nothing
      in_handler      <= irq_enter || (in_handler && !irq_return);
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fast_osc_force_on      <= power_save_pkg::OSC_RESET[power_save_pkg::FAST_FORCE_BIT];
      slow_osc_force_on      <= power_save_pkg::OSC_RESET[power_save_pkg::SLOW_FORCE_BIT];
      secondary_osc_force_on <= power_save_pkg::OSC_RESET[power_save_pkg::SEC_FORCE_BIT];
    end
    else if (osc_wr)
    begin
      fast_osc_force_on      <= wdata[power_save_pkg::FAST_FORCE_BIT];
      slow_osc_force_on      <= wdata[power_save_pkg::SLOW_FORCE_BIT];
      secondary_osc_force_on <= wdata[power_save_pkg::SEC_FORCE_BIT];
    end
  end

  // Event pulses and read data, all registered
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata             <= 8'h00;
      vector_fetch      <= 1'b0;
      wdt_clear         <= 1'b0;
      wdt_reset_request <= 1'b0;
      converter_abort   <= 1'b0;
      prev_doze_enable  <= 1'b0;
      prev_ratio        <= 3'h0;
    end
    else
    begin
      // Read data stand one cycle; the port reads zero otherwise
      rdata             <= rd ? read_value : 8'h00;
      vector_fetch      <= irq_enter;
      // Cleared on entry and again on leaving sleep; no other reset source here
      wdt_clear         <= sleep_go || (sleeping && wake);
      // Outside idle and sleep a timeout still resets the device
      wdt_reset_request <= running && wdt_timeout;
      // One-cycle pulse; software keeps converter_on set
      converter_abort   <= full_sleep_go && converter_on && !converter_rc_clock;
      // Last cycle's settings, kept to spot a change for the divider
      prev_doze_enable  <= doze_enable;
      prev_ratio        <= cpu_skip_ratio;
    end
  end

  assign vector_address = power_save_pkg::IRQ_VECTOR;

  // Divider link
  assign link.enable  = doze_enable;
  assign link.ratio   = cpu_skip_ratio;
  // Restart on any change so a new ratio never inherits a half-run slot
  assign link.restart = (doze_enable != prev_doze_enable)
                        || (cpu_skip_ratio != prev_ratio);

  // Only the core sees the throttle
  assign core_clock_enable         = running && link.run_cycle;
  assign periph_clock_enable       = !sleeping;
  assign periph_instr_clock_enable = !sleeping;
  assign system_clock_enable       = !sleeping;

  assign high_freq_internal_osc_enable = !sleeping || fast_osc_request
                                         || fast_osc_force_on;
  assign low_freq_internal_osc_enable  = !sleeping || slow_osc_request
                                         || slow_osc_force_on;
  assign secondary_osc_enable          = !sleeping || secondary_osc_request
                                         || secondary_osc_force_on;

  // The converter's own on bit is left set; only its power is cut
  assign converter_power = converter_on && !(sleeping && !converter_rc_clock);

  genvar p;
  generate
    for (p = 0; p < PINS; p++)
    begin : g_pin
      assign pin_hold[p] = sleeping && !pin_periph_active[p];
    end
  endgenerate

  // Global enable only gates vectoring upstream; folded into an unused wire, read nowhere
  wire unused_gie = global_irq_enable || idling;

endmodule

`default_nettype wire

// >>> rtl/doze_divider.sv
// Purpose: Produces the core run cycle, one in 2**(ratio+1) cycles under doze.
// Assumes: Ratio codes up to 7 fit in a CNT_W-bit counter.
// Notes:   The cycle right after a restart is always a run cycle.

`default_nettype none

module doze_divider #(
  parameter int unsigned CNT_W = 8
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Doze settings
  doze_link_if.div  link
);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] last_count;
  logic             wrap;

  // Period minus one: code 001 gives 1:4, code 100 gives 1:32
  assign last_count = CNT_W'((CNT_W+1)'(2) << link.ratio) - CNT_W'(1);
  assign wrap       = (count == last_count);
  assign link.run_cycle = !link.enable || (count == '0);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      count <= '0;
    else if (link.restart || !link.enable || wrap)
      count <= '0;
    else
      count <= count + CNT_W'(1);
  end

endmodule

`default_nettype wire

// >>> rtl/doze_link_if.sv
// Purpose: Carries doze settings to the throttle divider and its run cycle back.
// Assumes: Same clock as the controller.
// Notes:   restart is a one-cycle pulse.

`default_nettype none

interface doze_link_if;
  logic       enable;
  logic [2:0] ratio;
  logic       restart;
  logic       run_cycle;

  modport ctrl (output enable, output ratio, output restart, input run_cycle);
  modport div  (input enable, input ratio, input restart, output run_cycle);
endinterface

`default_nettype wire

// >>> rtl/power_save_pkg.sv
// Purpose: Shared constants for the processor power-saving mode controller.
// Assumes: 8-bit register port, one clock domain, active-low asynchronous reset.
// Notes:   Register offsets and field positions are used by the controller and the bench.

`default_nettype none

package power_save_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // Register offsets
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h01;
  localparam logic [7:0] OSC_OFFSET    = 8'h02;

  // Control register fields
  localparam int unsigned IDLE_SELECT_BIT = 7;
  localparam int unsigned DOZE_ENABLE_BIT = 6;
  localparam int unsigned RECOVER_BIT     = 5;
  localparam int unsigned RESUME_BIT      = 4;
  localparam int unsigned RATIO_LSB       = 0;
  localparam int unsigned RATIO_W         = 3;
  localparam logic [7:0]  CTRL_RESET      = 8'h00;

  // Status register fields
  localparam int unsigned PD_FLAG_BIT  = 0;
  localparam int unsigned TO_FLAG_BIT  = 1;
  localparam int unsigned MODE_LSB     = 2;
  localparam int unsigned HANDLER_BIT  = 4;
  localparam logic        PD_FLAG_RESET = 1'b1;
  localparam logic        TO_FLAG_RESET = 1'b1;

  // Oscillator force register fields
  localparam int unsigned FAST_FORCE_BIT = 0;
  localparam int unsigned SLOW_FORCE_BIT = 1;
  localparam int unsigned SEC_FORCE_BIT  = 2;
  localparam logic [2:0]  OSC_RESET      = 3'h0;

  // Ratio code for one in 32 core cycles
  localparam logic [2:0]  RATIO_1_32     = 3'h4;

  localparam logic [15:0] IRQ_VECTOR     = 16'h0004;

  typedef enum logic [1:0] {
    MODE_RUN   = 2'b00,
    MODE_IDLE  = 2'b01,
    MODE_SLEEP = 2'b10
  } power_mode_e;

endpackage

`default_nettype wire

// >>> testbench/core_model.sv
// Purpose: Processor core stand-in that runs a multicycle instruction.
// Assumes: The instruction advances only on clocked core cycles.
// Notes:   Length is a plain default, not a real core figure.
`default_nettype none
module core_model #(
  parameter int unsigned MULTI_LEN = 3
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Controller side
  input  wire logic core_clock_enable,
  input  wire logic start_multi,
  output logic      multicycle_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned left;
  // A gated core does not progress, so doze stretches the instruction
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      left <= 0;
    else if (start_multi)
      left <= MULTI_LEN;
    else if (core_clock_enable && left != 0)
      left <= left - 1;
  end
  assign multicycle_busy = (left != 0);
endmodule
`default_nettype wire

// >>> testbench/power_save_checker.sv
// Purpose: Port-level assertions for the power-saving mode controller.
// Assumes: Converter and request inputs are steady around sleep entry.
// Notes:   Full sleep shows at the ports as system_clock_enable low.
`default_nettype none
module power_save_checker #(
  parameter int unsigned PINS = 8
) (
  // Clock and reset
  input wire logic            clock,
  input wire logic            rst_n,
  // Register port and core
  input wire logic [7:0]      addr,
  input wire logic [7:0]      wdata,
  input wire logic            wr,
  input wire logic            irq_pending,
  input wire logic            multicycle_busy,
  input wire logic            vector_fetch,
  input wire logic [15:0]     vector_address,
  // Gating and side outputs
  input wire logic            core_clock_enable,
  input wire logic            periph_clock_enable,
  input wire logic            periph_instr_clock_enable,
  input wire logic            system_clock_enable,
  input wire logic            wdt_clear,
  input wire logic            slow_osc_request,
  input wire logic            low_freq_internal_osc_enable,
  input wire logic            converter_on,
  input wire logic            converter_rc_clock,
  input wire logic            converter_abort,
  input wire logic            converter_power,
  input wire logic [PINS-1:0] pin_periph_active,
  input wire logic [PINS-1:0] pin_hold
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  sequence doze_write;
    wr && addr == power_save_pkg::CTRL_OFFSET && wdata == 8'h44;
  endsequence
  // Cycle right after the update is left open; the run slot follows it
  sequence run_then_skip;
    ##2 core_clock_enable ##1 !core_clock_enable [*8];
  endsequence
  a_doze_one_32: assert property (doze_write |-> run_then_skip)
    else $error("doze 1:32 run pattern wrong");
  a_periph_full: assert property (periph_clock_enable == system_clock_enable
    && periph_instr_clock_enable == system_clock_enable)
    else $error("peripheral clocks not at full speed");
  a_sleep_gates: assert property (!system_clock_enable |-> !core_clock_enable)
    else $error("core clocked in sleep");
  a_sleep_wdt_clear: assert property ($fell(system_clock_enable) |-> wdt_clear)
    else $error("watchdog not cleared on sleep");
  a_slow_osc_kept: assert property (system_clock_enable || slow_osc_request
    |-> low_freq_internal_osc_enable)
    else $error("requested slow oscillator stopped");
  a_conv_power: assert property (converter_power ==
    (converter_on && (system_clock_enable || converter_rc_clock)))
    else $error("converter power wrong");
  a_conv_abort: assert property ($fell(system_clock_enable) && converter_on
    && !converter_rc_clock |-> converter_abort)
    else $error("conversion not aborted");
  a_pin_hold: assert property (pin_hold ==
    ({PINS{!system_clock_enable}} & ~pin_periph_active))
    else $error("pin hold wrong");
  a_busy_no_vector: assert property (multicycle_busy |=> !vector_fetch)
    else $error("vector fetched during multicycle");
  a_vector_addr: assert property (vector_fetch |->
    vector_address == power_save_pkg::IRQ_VECTOR)
    else $error("vector address wrong");
  a_irq_wakes: assert property (irq_pending && !system_clock_enable
    |=> system_clock_enable)
    else $error("interrupt did not wake");
endmodule
bind cpu_power_save_modes power_save_checker #(.PINS(PINS)) chk (
  .clock, .rst_n, .addr, .wdata, .wr, .irq_pending, .multicycle_busy,
  .vector_fetch, .vector_address, .core_clock_enable, .periph_clock_enable,
  .periph_instr_clock_enable, .system_clock_enable, .wdt_clear, .slow_osc_request,
  .low_freq_internal_osc_enable, .converter_on, .converter_rc_clock,
  .converter_abort, .converter_power, .pin_periph_active, .pin_hold
);
`default_nettype wire

// >>> testbench/tb_top.sv
// Purpose: Self-checking bench for the power-saving mode controller.
// Assumes: Read data is sampled in the cycle after the read strobe.
// Notes:   Vector waits are bounded at 20 cycles.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock, rst_n, wr, rd, sleep_exec, irq_pending, irq_request, global_irq_enable;
  logic       prefetch_clears_gie, multicycle_busy, irq_return, vector_fetch, start_multi;
  logic       core_clock_enable, periph_clock_enable, periph_instr_clock_enable;
  logic       system_clock_enable, wdt_timeout, wdt_clear, wdt_reset_request;
  logic       fast_osc_request, slow_osc_request, secondary_osc_request;
  logic       high_freq_internal_osc_enable, low_freq_internal_osc_enable;
  logic       secondary_osc_enable, converter_on, converter_rc_clock;
  logic       converter_abort, converter_power;
  logic [7:0] addr, wdata, rdata, pin_periph_active, pin_hold, d;
  logic [15:0] vector_address;
  int         miscompares, compares;
  cpu_power_save_modes dut (.clock, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .sleep_exec,
    .irq_pending, .irq_request, .global_irq_enable, .prefetch_clears_gie, .multicycle_busy,
    .irq_return, .vector_fetch, .vector_address, .core_clock_enable, .periph_clock_enable,
    .periph_instr_clock_enable, .system_clock_enable, .wdt_timeout, .wdt_clear,
    .wdt_reset_request, .fast_osc_request, .slow_osc_request, .secondary_osc_request,
    .high_freq_internal_osc_enable, .low_freq_internal_osc_enable, .secondary_osc_enable,
    .converter_on, .converter_rc_clock, .converter_abort, .converter_power,
    .pin_periph_active, .pin_hold);
  core_model core (.clock, .rst_n, .core_clock_enable, .start_multi, .multicycle_busy);
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    wr <= 1'b1; addr <= a; wdata <= v;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clock);
    rd <= 1'b1; addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // 0 sleep instruction, 1 watchdog timeout, 2 interrupt return
  task automatic pulse(input int k);
    @(posedge clock);
    sleep_exec <= (k == 0); wdt_timeout <= (k == 1); irq_return <= (k == 2);
    @(posedge clock);
    sleep_exec <= 1'b0; wdt_timeout <= 1'b0; irq_return <= 1'b0;
    #1;
  endtask
  task automatic wait_vec(output int n);
    n = 0;
    do
    begin
      @(posedge clock);
      #1 n++;
    end
    while (vector_fetch !== 1'b1 && n < 20);
    @(posedge clock);
    irq_request <= 1'b0;
    if (n >= 20) chk1(1'b0, 1'b1);
  endtask
  task automatic end_sim();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial
  begin
    #200us;
    miscompares++;
    end_sim();
  end
  initial
  begin
    int n, cnt;
    logic dz, rc;
    {rst_n, wr, rd, sleep_exec, irq_pending, irq_request, global_irq_enable} = '0;
    {prefetch_clears_gie, irq_return, start_multi, wdt_timeout, converter_rc_clock} = '0;
    {fast_osc_request, slow_osc_request, secondary_osc_request} = '0;
    {addr, wdata} = '0;
    converter_on = 1'b1;
    pin_periph_active = 8'h0f;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    wr_reg(8'h01, 8'hff);
    rd_reg(8'h01); chk8(d, 8'h03);
    rd_reg(8'h03); chk8(d, 8'h00);
    rd_reg(8'h02); chk8(d, 8'h00);
    for (int r = 0; r < 5; r++)
    begin
      wr_reg(8'h00, 8'h40 | 8'(r));
      cnt = 0;
      repeat (4 << (r + 1))
      begin
        @(posedge clock);
        #1 if (core_clock_enable === 1'b1) cnt++;
      end
      chk8(8'(cnt), 8'h04);
    end
    for (int k = 0; k < 4; k++)
    begin
      dz = k[1];
      rc = k[0];
      wr_reg(8'h00, {1'b0, dz, rc, 5'h00});
      @(posedge clock);
      irq_request <= 1'b1;
      wait_vec(n);
      rd_reg(8'h00); chk8(d, {1'b0, dz & !rc, rc, dz, 4'h0});
      rd_reg(8'h01); chk8(d, 8'h13);
      wr_reg(8'h00, {1'b0, dz & !rc, rc, !dz, 4'h0});
      pulse(2);
      rd_reg(8'h00); chk8(d, {1'b0, !dz, rc, !dz, 4'h0});
    end
    wr_reg(8'h00, 8'h00);
    @(posedge clock);
    start_multi <= 1'b1;
    @(posedge clock);
    start_multi <= 1'b0; irq_request <= 1'b1;
    wait_vec(n);
    chk1(n > 3, 1'b1);
    pulse(2);
    wr_reg(8'h00, 8'h40);
    @(posedge clock);
    irq_request <= 1'b1; prefetch_clears_gie <= 1'b1;
    @(posedge clock);
    irq_request <= 1'b0; prefetch_clears_gie <= 1'b0;
    rd_reg(8'h00); chk1(d[6], 1'b0);
    rd_reg(8'h01); chk8(d, 8'h03);
    wr_reg(8'h02, 8'h02);
    pulse(0);
    chk1(system_clock_enable, 1'b0);
    chk1(low_freq_internal_osc_enable, 1'b1);
    chk1(high_freq_internal_osc_enable, 1'b0);
    chk1(secondary_osc_enable, 1'b0);
    chk1(converter_power, 1'b0);
    chk8(pin_hold, 8'hf0);
    rd_reg(8'h01); chk8(d, 8'h0a);
    @(posedge clock);
    irq_pending <= 1'b1;
    @(posedge clock);
    #1 chk1(system_clock_enable, 1'b1);
    chk1(wdt_clear, 1'b1);
    pulse(0);
    rd_reg(8'h01); chk8(d, 8'h02);
    @(posedge clock);
    irq_pending <= 1'b0;
    wr_reg(8'h00, 8'h80);
    pulse(0);
    chk1(core_clock_enable, 1'b0);
    chk1(periph_clock_enable, 1'b1);
    rd_reg(8'h01); chk8(d, 8'h06);
    pulse(1);
    chk1(wdt_reset_request, 1'b0);
    chk1(core_clock_enable, 1'b1);
    rd_reg(8'h00); chk8(d, 8'h80);
    wr_reg(8'h00, 8'h00);
    pulse(1);
    chk1(wdt_reset_request, 1'b1);
    end_sim();
  end
endmodule
`default_nettype wire
